//--- hdl/didf_regs.svh
// register map, field positions, reset values and timing counts of the
// digital input function dispatch block; definitions only.
// assumes one 20 MHz clock and single-word AHB-Lite accesses.
//
// Behaviour
// - code 0 is unused, triggers nothing; every input holds it after reset.
// - code 1 clears active faults once on activation; holding repeats nothing.
// - a fault whose cause persists stays set after a clear attempt.
// - code 2 rising edge starts the motion task numbered by the input argument.
// - codes 2 to 5 act only in position mode with service source.
// - after an input starts a task, its changes are ignored until done.
// - all task-start inputs are ignored while any started task runs.
// - a task-start change while a task executes starts nothing.
// - code 3 inputs form a binary task number, lowest input weight one.
// - code 4 rising edge starts the selected task, task 0 homes.
// - code 5 rising edge starts homing; falling edge does nothing.
// - code 6 rising starts jog at argument velocity, falling stops it.
// - code 8 rising edge captures scaled position as zero-pulse offset.
// - after that capture, settings are saved to nonvolatile storage.
// - code 9 argument 1 to 4 picks a buffer set, low and high.
// - code 9 rising runs the high buffer, falling runs the low one.
// - codes 0, 1, 8 and 9 act in every mode and source.
// - every input is debounced so switch bounce gives one trigger.
// - the enable input is fixed and never a programmable input.
`ifndef DIDF_REGS_SVH
`define DIDF_REGS_SVH

// ****************************************************************
// register offsets (byte addresses)
// ****************************************************************
`define DIDF_CTRL_OFS 12'h000
`define DIDF_STATUS_OFS 12'h004
`define DIDF_FAULT_OFS 12'h008
`define DIDF_ZERO_OFS 12'h00C
`define DIDF_CFG_BASE 12'h040

// ****************************************************************
// fields
// ****************************************************************
`define DIDF_CTRL_OPMODE_LSB 0
`define DIDF_CTRL_CMDSRC_LSB 2
`define DIDF_CTRL_ENC_LSB 4
`define DIDF_STAT_ENABLE_BIT 16
`define DIDF_STAT_MOTION_BIT 17
`define DIDF_STAT_JOG_BIT 18
`define DIDF_CFG_ARG_LSB 16

// ****************************************************************
// reset values and codes
// ****************************************************************
`define DIDF_OPMODE_RST 2'h0
`define DIDF_CMDSRC_RST 2'h0
`define DIDF_ENC_RST 6'h10
`define DIDF_OPMODE_VEL 2'h1
`define DIDF_OPMODE_POS 2'h2
`define DIDF_CMDSRC_SERVICE 2'h0
`define DIDF_TASK_HOME 7'h00
`define DIDF_BUF_SETS 4

// ****************************************************************
// timing
// ****************************************************************
`define DIDF_CLK_MHZ 20
`define DIDF_DEB_US 1000
`define DIDF_DEB_CYC (`DIDF_DEB_US * `DIDF_CLK_MHZ)
`define DIDF_N_IN_DEF 7
`define DIDF_N_FAULT_DEF 8

`endif

//--- hdl/didf_pkg.sv
// types used by the dispatch block, including the layout of its configuration memory words.
// assumes the constants header is included by the user modules.
package didf_pkg;

  // ****************************************************************
  // input function codes; 7 and 10 upward act as unused
  // ****************************************************************
  typedef enum logic [4:0] {
    DIDF_FN_OFF = 5'h00,
    DIDF_FN_FAULT_RESET = 5'h01,
    DIDF_FN_TASK_ARG = 5'h02,
    DIDF_FN_SELECT_BIT = 5'h03,
    DIDF_FN_TASK_SELECTED = 5'h04,
    DIDF_FN_HOME = 5'h05,
    DIDF_FN_JOG = 5'h06,
    DIDF_FN_ZERO_LATCH = 5'h08,
    DIDF_FN_CMD_BUFFER = 5'h09
  } didf_func_t;

  // one configuration word per input
  typedef struct packed {
    logic [15:0] input_function_argument;
    logic [10:0] rsvd;
    logic [4:0] input_function_code;
  } didf_cfg_t;

endpackage

//--- hdl/didf_cfg_mem.sv
// per-input configuration memory: one bus port and one scan port,
// both with registered read data.
// assumes the bus never reads and writes one word in the same cycle.
`timescale 1ns/1ps
module didf_cfg_mem #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 7,
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1
)(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic a_we,
  input wire logic [AW-1:0] a_addr,
  input wire logic [WIDTH-1:0] a_wdata,
  output logic [WIDTH-1:0] a_rdata,
  input wire logic [AW-1:0] b_addr,
  output logic [WIDTH-1:0] b_rdata
);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] word;
    logic [WIDTH-1:0] a_q;
    logic [WIDTH-1:0] b_q;
  } didf_mem_st_t;

  didf_mem_st_t st;
  didf_mem_st_t next_st;

  if (DEPTH < 1 || WIDTH < 1)
  begin : g_chk
    $error("didf_cfg_mem: bad geometry");
  end

  always_comb
  begin
    next_st = st;
    next_st.a_q = '0;
    next_st.b_q = '0;
    if (a_we && int'(a_addr) < DEPTH)
    begin
      next_st.word[a_addr] = a_wdata;
    end
    if (int'(a_addr) < DEPTH)
    begin
      next_st.a_q = st.word[a_addr];
    end
    if (int'(b_addr) < DEPTH)
    begin
      next_st.b_q = st.word[b_addr];
    end
  end

  // all words reset to zero, which is the unused function code
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st <= '0;
    end
    else if (ce)
    begin
      st <= next_st;
    end
  end

  assign a_rdata = st.a_q;
  assign b_rdata = st.b_q;

endmodule

//--- hdl/didf_dispatch.sv
// digital input function dispatch: debounces the input pins, scans the
// per-input configuration and raises task, homing, jog, fault-clear,
// zero-latch and command-buffer requests; AHB-Lite slave for registers.
// assumes a motion engine that reports busy/done and a buffer interpreter.
//
// Register access over AHB-Lite and the register offsets were decided locally.
`timescale 1ns/1ps
`include "didf_regs.svh"
module didf_dispatch
  import didf_pkg::*;
#(
  parameter int N_IN = `DIDF_N_IN_DEF,
  parameter int N_FAULT = `DIDF_N_FAULT_DEF,
  parameter int DEB_CYCLES = `DIDF_DEB_CYC
)(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [N_IN-1:0] din,
  input wire logic enable_pin,
  input wire logic motion_busy,
  input wire logic motion_done,
  input wire logic [31:0] position,
  input wire logic [N_FAULT-1:0] fault_cause,
  output logic drive_enable,
  output logic task_start,
  output logic [6:0] task_number,
  output logic home_start,
  output logic jog_start,
  output logic jog_stop,
  output logic [15:0] jog_velocity,
  output logic [N_FAULT-1:0] fault_active,
  output logic [31:0] zero_offset,
  output logic nv_save,
  output logic cmd_exec,
  output logic [1:0] cmd_set,
  output logic cmd_high
);

  localparam int NB = N_IN + 1;
  localparam int AW = (N_IN > 1) ? $clog2(N_IN) : 1;
  localparam int TW = $clog2(DEB_CYCLES + 1);

  // ****************************************************************
  // elaboration checks
  // ****************************************************************
  if (N_IN < 1 || N_IN > 16 || N_FAULT < 1 || N_FAULT > 32)
  begin : g_chk_size
    $error("didf_dispatch: unsupported input or fault count");
  end
  if (DEB_CYCLES < 2)
  begin : g_chk_deb
    $error("didf_dispatch: debounce period too short");
  end

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [NB-1:0] s1;
    logic [NB-1:0] s2;
    logic [NB-1:0] s3;
    logic [NB-1:0] smp;
    logic [NB-1:0] lvl;
    logic [TW-1:0] tick_cnt;
    logic [N_IN-1:0] rpend;
    logic [N_IN-1:0] fpend;
    logic [N_IN-1:0] sel_mask;
    logic [AW-1:0] scan_idx;
    logic [AW-1:0] proc_idx;
    logic proc_vld;
    logic [1:0] opmode;
    logic [1:0] cmdsrc;
    logic [5:0] enc_bits;
    logic task_lock;
    logic jog_on;
    logic [N_FAULT-1:0] fault;
    logic [31:0] zero;
    logic nv_pend;
    logic task_start;
    logic [6:0] task_num;
    logic home_start;
    logic jog_start;
    logic jog_stop;
    logic [15:0] jog_vel;
    logic nv_save;
    logic cmd_exec;
    logic [1:0] cmd_set;
    logic cmd_high;
    logic d_vld;
    logic d_wr;
    logic [11:2] d_addr;
  } didf_st_t;

  didf_st_t st;
  didf_st_t next_st;

  // ****************************************************************
  // helpers
  // ****************************************************************
  // packs the select-bit inputs, lowest selected input as weight one
  function automatic logic [6:0] didf_sel_num(input logic [N_IN-1:0] lvl,
                                              input logic [N_IN-1:0] mask);
    logic [6:0] n;
    int unsigned k;
    n = '0;
    k = 0;
    for (int i = 0; i < N_IN; i++)
    begin
      if (mask[i])
      begin
        if (k < 7 && lvl[i])
        begin
          n[k[2:0]] = 1'b1;
        end
        k++;
      end
    end
    return n;
  endfunction

  // position reduced to the configured encoder resolution
  function automatic logic [31:0] didf_scale(input logic [31:0] pos,
                                             input logic [5:0] bits);
    if (bits == 6'h00 || bits >= 6'h20)
    begin
      return pos;
    end
    return pos >> (6'h20 - bits);
  endfunction

  // ****************************************************************
  // bus decode and configuration memory
  // ****************************************************************
  logic a_phase;
  logic cfg_hit_d;
  logic mem_we;
  logic [AW-1:0] mem_a_addr;
  logic [31:0] mem_a_rdata;
  logic [31:0] mem_b_rdata;
  logic [11:0] a_ofs;
  logic [11:0] d_ofs;
  didf_cfg_t cfg;

  assign a_phase = hsel && htrans[1] && hready;
  assign a_ofs = {haddr[11:2], 2'b00};
  assign d_ofs = {st.d_addr, 2'b00};
  assign cfg_hit_d = d_ofs >= `DIDF_CFG_BASE &&
                     d_ofs < `DIDF_CFG_BASE + 12'(4 * N_IN);
  assign mem_we = st.d_vld && st.d_wr && cfg_hit_d;
  // a write in its data phase owns the port; the master idles meanwhile
  assign mem_a_addr = mem_we ? AW'((d_ofs - `DIDF_CFG_BASE) >> 2)
                             : AW'((a_ofs - `DIDF_CFG_BASE) >> 2);
  assign cfg = didf_cfg_t'(mem_b_rdata);

  didf_cfg_mem #(
    .WIDTH(32),
    .DEPTH(N_IN)
  ) u_cfg (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .a_we(mem_we),
    .a_addr(mem_a_addr),
    .a_wdata(hwdata),
    .a_rdata(mem_a_rdata),
    .b_addr(st.scan_idx),
    .b_rdata(mem_b_rdata)
  );

  // ****************************************************************
  // next state
  // ****************************************************************
  logic tick;
  logic [NB-1:0] agree;
  logic [NB-1:0] cand;
  logic [NB-1:0] same;
  logic pos_ok;
  logic jog_ok;
  logic motion_act;
  logic rise;
  logic fall;
  logic [6:0] sel_num;

  always_comb
  begin
    next_st = st;
    next_st.task_start = 1'b0;
    next_st.home_start = 1'b0;
    next_st.jog_start = 1'b0;
    next_st.jog_stop = 1'b0;
    next_st.nv_save = 1'b0;
    next_st.cmd_exec = 1'b0;
    next_st.nv_pend = 1'b0;

    // three-stage synchroniser; first stage feeds only the second
    next_st.s1 = {enable_pin, din};
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;

    // a change counts once stages two and three agree, then must hold
    // over two debounce ticks; bounce shorter than a tick is lost
    tick = st.tick_cnt == TW'(DEB_CYCLES - 1);
    next_st.tick_cnt = tick ? '0 : st.tick_cnt + 1'b1;
    agree = ~(st.s2 ^ st.s3);
    cand = (st.s3 & agree) | (st.smp & ~agree);
    same = ~(cand ^ st.smp);
    if (tick)
    begin
      next_st.smp = cand;
      next_st.lvl = (cand & same) | (st.lvl & ~same);
    end

    // edges of the debounced level only, enable bit excluded
    next_st.rpend = st.rpend | (next_st.lvl[N_IN-1:0] & ~st.lvl[N_IN-1:0]);
    next_st.fpend = st.fpend | (~next_st.lvl[N_IN-1:0] & st.lvl[N_IN-1:0]);

    // faults latch while their cause is present
    next_st.fault = st.fault | fault_cause;
    if (motion_done)
    begin
      next_st.task_lock = 1'b0;
    end

    // scanner: one configuration word read per cycle
    next_st.scan_idx = (st.scan_idx == AW'(N_IN - 1)) ? '0 : st.scan_idx + 1'b1;
    next_st.proc_idx = st.scan_idx;
    next_st.proc_vld = 1'b1;

    pos_ok = st.opmode == `DIDF_OPMODE_POS &&
             st.cmdsrc == `DIDF_CMDSRC_SERVICE;
    jog_ok = (st.opmode == `DIDF_OPMODE_VEL ||
              st.opmode == `DIDF_OPMODE_POS) &&
             st.cmdsrc == `DIDF_CMDSRC_SERVICE;
    motion_act = st.task_lock || motion_busy;
    rise = st.proc_vld && st.rpend[st.proc_idx];
    fall = st.proc_vld && st.fpend[st.proc_idx];
    sel_num = didf_sel_num(st.lvl[N_IN-1:0], st.sel_mask);

    if (st.proc_vld)
    begin
      // consumed edges clear, but an edge arriving now is kept
      next_st.rpend[st.proc_idx] = next_st.lvl[st.proc_idx] &
                                   ~st.lvl[st.proc_idx];
      next_st.fpend[st.proc_idx] = ~next_st.lvl[st.proc_idx] &
                                   st.lvl[st.proc_idx];
      next_st.sel_mask[st.proc_idx] =
        cfg.input_function_code == DIDF_FN_SELECT_BIT;
      case (cfg.input_function_code)
        DIDF_FN_FAULT_RESET:
        begin
          // once per activation; persisting causes win the clear
          if (rise)
          begin
            next_st.fault = fault_cause;
          end
        end
        DIDF_FN_TASK_ARG:
        begin
          // edges during a running task are dropped, not queued
          if (rise && pos_ok && !motion_act)
          begin
            next_st.task_start = 1'b1;
            next_st.task_num = cfg.input_function_argument[6:0];
            next_st.task_lock = 1'b1;
          end
        end
        DIDF_FN_TASK_SELECTED:
        begin
          if (rise && pos_ok && !motion_act)
          begin
            next_st.task_lock = 1'b1;
            if (sel_num == `DIDF_TASK_HOME)
            begin
              next_st.home_start = 1'b1;
            end
            else
            begin
              next_st.task_start = 1'b1;
              next_st.task_num = sel_num;
            end
          end
        end
        DIDF_FN_HOME:
        begin
          if (rise && pos_ok && !motion_act)
          begin
            next_st.home_start = 1'b1;
            next_st.task_lock = 1'b1;
          end
        end
        DIDF_FN_JOG:
        begin
          if (rise && jog_ok && !st.jog_on)
          begin
            next_st.jog_start = 1'b1;
            next_st.jog_vel = cfg.input_function_argument;
            next_st.jog_on = 1'b1;
          end
          // stop is honoured in any mode so a jog never runs on
          if (fall && st.jog_on)
          begin
            next_st.jog_stop = 1'b1;
            next_st.jog_on = 1'b0;
          end
        end
        DIDF_FN_ZERO_LATCH:
        begin
          if (rise)
          begin
            next_st.zero = didf_scale(position, st.enc_bits);
            next_st.nv_pend = 1'b1;
          end
        end
        DIDF_FN_CMD_BUFFER:
        begin
          // arguments outside 1..4 select no set
          if ((rise || fall) && cfg.input_function_argument >= 16'h0001 &&
              cfg.input_function_argument <= 16'(`DIDF_BUF_SETS))
          begin
            next_st.cmd_exec = 1'b1;
            next_st.cmd_set = 2'(cfg.input_function_argument - 16'h0001);
            next_st.cmd_high = rise;
          end
        end
        default:
        begin
          // unused, select-bit and reserved codes start nothing
          next_st.task_lock = next_st.task_lock;
        end
      endcase
    end

    // save follows the capture by one cycle
    if (st.nv_pend)
    begin
      next_st.nv_save = 1'b1;
    end

    // ****************************************************************
    // bus: address phase latch, data phase write
    // ****************************************************************
    next_st.d_vld = a_phase;
    next_st.d_wr = a_phase && hwrite;
    if (a_phase)
    begin
      next_st.d_addr = haddr[11:2];
    end
    if (st.d_vld && st.d_wr && d_ofs == `DIDF_CTRL_OFS)
    begin
      next_st.opmode = hwdata[`DIDF_CTRL_OPMODE_LSB +: 2];
      next_st.cmdsrc = hwdata[`DIDF_CTRL_CMDSRC_LSB +: 2];
      next_st.enc_bits = hwdata[`DIDF_CTRL_ENC_LSB +: 6];
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st <= '0;
      st.opmode <= `DIDF_OPMODE_RST;
      st.cmdsrc <= `DIDF_CMDSRC_RST;
      st.enc_bits <= `DIDF_ENC_RST;
    end
    else if (ce)
    begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // read mux and outputs
  // ****************************************************************
  always_comb
  begin
    hrdata = '0;
    if (st.d_vld && !st.d_wr)
    begin
      if (cfg_hit_d)
      begin
        hrdata = mem_a_rdata;
      end
      else
      begin
        case (d_ofs)
          `DIDF_CTRL_OFS:
          begin
            hrdata[`DIDF_CTRL_OPMODE_LSB +: 2] = st.opmode;
            hrdata[`DIDF_CTRL_CMDSRC_LSB +: 2] = st.cmdsrc;
            hrdata[`DIDF_CTRL_ENC_LSB +: 6] = st.enc_bits;
          end
          `DIDF_STATUS_OFS:
          begin
            hrdata[N_IN-1:0] = st.lvl[N_IN-1:0];
            hrdata[`DIDF_STAT_ENABLE_BIT] = st.lvl[N_IN];
            hrdata[`DIDF_STAT_MOTION_BIT] = st.task_lock || motion_busy;
            hrdata[`DIDF_STAT_JOG_BIT] = st.jog_on;
          end
          `DIDF_FAULT_OFS:
          begin
            hrdata[N_FAULT-1:0] = st.fault;
          end
          `DIDF_ZERO_OFS:
          begin
            hrdata = st.zero;
          end
          default:
          begin
            hrdata = '0;
          end
        endcase
      end
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  // the enable pin is never routed through the programmable functions
  assign drive_enable = st.lvl[N_IN];
  assign task_start = st.task_start;
  assign task_number = st.task_num;
  assign home_start = st.home_start;
  assign jog_start = st.jog_start;
  assign jog_stop = st.jog_stop;
  assign jog_velocity = st.jog_vel;
  assign fault_active = st.fault;
  assign zero_offset = st.zero;
  assign nv_save = st.nv_save;
  assign cmd_exec = st.cmd_exec;
  assign cmd_set = st.cmd_set;
  assign cmd_high = st.cmd_high;

endmodule

//--- dv/didf_dispatch_props.sv
// port checker for the dispatch block, bound to didf_dispatch
// assumes ce stays high so no flop freezes
`timescale 1ns/1ps
module didf_dispatch_props #(
  parameter int N_FAULT = 8
)(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic motion_busy,
  input wire logic motion_done,
  input wire logic [N_FAULT-1:0] fault_cause,
  input wire logic [N_FAULT-1:0] fault_active,
  input wire logic task_start,
  input wire logic home_start,
  input wire logic jog_start,
  input wire logic [15:0] jog_velocity,
  input wire logic [31:0] zero_offset,
  input wire logic nv_save,
  input wire logic cmd_exec,
  input wire logic cmd_high
);
  // ****************************************************************
  // start lock seen from outside
  // ****************************************************************
  logic lock;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      lock <= 1'h0;
    else if (task_start || home_start)
      lock <= 1'h1;
    else if (motion_done)
      lock <= 1'h0;
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_bus_okay: assert property (hreadyout && !hresp) else $error("bus wait or error");
  a_start_pulse: assert property (task_start |=> !task_start)
    else $error("task start longer than one cycle");
  a_lock_holds: assert property (lock |-> !task_start && !home_start)
    else $error("start while a task runs");
  a_busy_blocks: assert property ($past(motion_busy) |-> !task_start && !home_start)
    else $error("start while motion busy");
  a_home_alone: assert property (home_start |-> !task_start)
    else $error("homing and task started together");
  a_fault_kept: assert property ((fault_active & $past(fault_cause)) == $past(fault_cause))
    else $error("fault with live cause not active");
  a_save_follows: assert property ($changed(zero_offset) |=> nv_save)
    else $error("no save after offset capture");
  a_jog_vel_hold: assert property (!jog_start |-> $stable(jog_velocity))
    else $error("jog velocity moved without jog start");
  c_task: cover property (task_start);
  c_home: cover property (home_start);
  c_cmd_high: cover property (cmd_exec && cmd_high);
  c_save: cover property (nv_save);
endmodule

bind didf_dispatch didf_dispatch_props #(.N_FAULT(N_FAULT)) didf_dispatch_props_i (.hclk,
  .hresetn, .hreadyout, .hresp, .motion_busy, .motion_done, .fault_cause, .fault_active,
  .task_start, .home_start, .jog_start, .jog_velocity, .zero_offset, .nv_save, .cmd_exec,
  .cmd_high);

//--- dv/didf_switch_bank.sv
// bouncing switches in front of the input pins and the enable pin
// assumes one process at a time calls set()
`timescale 1ns/1ps
module didf_switch_bank #(
  parameter int N = 8
)(
  input wire logic hclk,
  output logic [N-1:0] sw
);
  initial sw = '0;
  // bounce stays shorter than one debounce tick, as a real contact would
  task automatic set(input int i, input logic v);
    repeat (2)
    begin
      @(posedge hclk);
      sw[i] <= v;
      @(posedge hclk);
      sw[i] <= ~v;
    end
    @(posedge hclk);
    sw[i] <= v;
  endtask
endmodule

//--- dv/didf_dispatch_tb.sv
// self-checking bench for didf_dispatch with a short debounce count
// assumes the switch model and the bound port checker
`timescale 1ns/1ps
`include "didf_regs.svh"
module didf_dispatch_tb;
  logic hclk = 0;
  logic hresetn = 0;
  logic hsel = 0, hwrite = 0, motion_busy = 0, motion_done = 0;
  logic [1:0] htrans = 2'h0, cmd_set;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, position = 32'h0, hrdata, zero_offset, q;
  logic [7:0] fault_cause = 8'h00, fault_active, sw;
  logic [6:0] task_number, last_num;
  logic [15:0] jog_velocity;
  logic [2:0] last_cmd;
  logic hreadyout, hresp, drive_enable, task_start, home_start, jog_start, jog_stop;
  logic nv_save, cmd_exec, cmd_high;
  int fail_count = 0, total_checks = 0, busy_cnt = 0;
  int n_task = 0, n_home = 0, n_js = 0, n_jp = 0, n_cmd = 0, n_nv = 0;

  initial forever #25 hclk = ~hclk;

  didf_dispatch #(.DEB_CYCLES(8)) didf_dispatch_i (.hclk, .hresetn, .ce(1'h1), .hsel,
    .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata,
    .hreadyout, .hresp, .din(sw[6:0]), .enable_pin(sw[7]), .motion_busy, .motion_done,
    .position, .fault_cause, .drive_enable, .task_start, .task_number, .home_start,
    .jog_start, .jog_stop, .jog_velocity, .fault_active, .zero_offset, .nv_save,
    .cmd_exec, .cmd_set, .cmd_high);
  didf_switch_bank #(.N(8)) didf_switch_bank_i (.hclk, .sw);

  // ****************************************************************
  // motion engine stand-in and pulse counters
  // ****************************************************************
  always @(posedge hclk)
  begin
    motion_done <= 1'h0;
    n_js += (jog_start === 1'h1);
    n_jp += (jog_stop === 1'h1);
    n_nv += (nv_save === 1'h1);
    n_home += (home_start === 1'h1);
    if (task_start === 1'h1)
    begin
      n_task++;
      last_num = task_number;
    end
    if (cmd_exec === 1'h1)
    begin
      n_cmd++;
      last_cmd = {cmd_set, cmd_high};
    end
    busy_cnt -= (busy_cnt > 0);
    // long run so a second edge lands while the task is still going
    if (task_start === 1'h1 || home_start === 1'h1)
    begin
      motion_busy <= 1'h1;
      busy_cnt = 300;
    end
    else if (busy_cnt == 1)
    begin
      motion_busy <= 1'h0;
      motion_done <= 1'h1;
    end
  end

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e)
    begin
      $display("ERROR %s expected %h seen %h", n, e, s);
      fail_count++;
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'h1;
    haddr <= {20'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    q = hrdata;
  endtask
  task automatic cfg(input int i, input logic [4:0] c, input logic [15:0] arg);
    bus(1'h1, `DIDF_CFG_BASE + 12'(4 * i), {arg, 11'h0, c});
  endtask
  task automatic mode(input logic [1:0] op);
    bus(1'h1, `DIDF_CTRL_OFS, 32'h100 | op);
  endtask
  task automatic press(input int i, input logic v);
    didf_switch_bank_i.set(i, v);
    repeat (60) @(posedge hclk);
  endtask
  task automatic idle;
    for (int k = 0; k < 400 && motion_busy; k++) @(posedge hclk);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset;
    bus(1'h0, `DIDF_CTRL_OFS, 32'h0);
    chk("ctrl", 32'h100, q);
    bus(1'h0, `DIDF_CFG_BASE, 32'h0);
    chk("cfg0", 32'h0, q);
    bus(1'h1, 12'h0F0, 32'hFFFF_FFFF);
    bus(1'h0, 12'h0F0, 32'h0);
    chk("unmapped", 32'h0, q);
    $display("reset test done");
  endtask
  task automatic t_task;
    cfg(0, 5'h02, 16'h5);
    mode(2'h1);
    press(0, 1'h1);
    chk("velocity mode start", 0, n_task);
    press(0, 1'h0);
    mode(2'h2);
    press(0, 1'h1);
    chk("task count", 1, n_task);
    chk("task number", 7'h05, last_num);
    press(0, 1'h0);
    press(0, 1'h1);
    chk("start while running", 1, n_task);
    idle();
    press(0, 1'h0);
    $display("task start test done");
  endtask
  task automatic t_select;
    cfg(1, 5'h03, 16'h0);
    cfg(2, 5'h03, 16'h0);
    cfg(3, 5'h04, 16'h0);
    press(2, 1'h1);
    press(3, 1'h1);
    chk("selected task", 2, n_task);
    chk("selected number", 7'h02, last_num);
    idle();
    press(3, 1'h0);
    chk("falling select start", 2, n_task);
    press(2, 1'h0);
    press(3, 1'h1);
    chk("task zero homes", 1, n_home);
    idle();
    cfg(3, 5'h05, 16'h0);
    press(3, 1'h0);
    press(3, 1'h1);
    chk("home input", 2, n_home);
    idle();
    press(3, 1'h0);
    $display("select test done");
  endtask
  task automatic t_jog;
    cfg(4, 5'h06, 16'h1234);
    press(4, 1'h1);
    chk("jog start", 1, n_js);
    chk("jog velocity", 16'h1234, jog_velocity);
    press(4, 1'h0);
    chk("jog stop", 1, n_jp);
    mode(2'h0);
    press(4, 1'h1);
    chk("jog in torque mode", 1, n_js);
    press(4, 1'h0);
    $display("jog test done");
  endtask
  task automatic t_fault;
    fault_cause <= 8'h0F;
    @(posedge hclk);
    fault_cause <= 8'h05;
    cfg(5, 5'h01, 16'h0);
    chk("sticky faults", 8'h0F, fault_active);
    press(5, 1'h1);
    chk("fault clear", 8'h05, fault_active);
    fault_cause <= 8'h00;
    repeat (60) @(posedge hclk);
    chk("held input", 8'h05, fault_active);
    press(5, 1'h0);
    $display("fault test done");
  endtask
  task automatic t_misc;
    position <= 32'hABCD_1234;
    cfg(6, 5'h08, 16'h0);
    press(6, 1'h1);
    chk("zero offset", 32'h0000_ABCD, zero_offset);
    chk("saves", 1, n_nv);
    cfg(0, 5'h09, 16'h3);
    press(0, 1'h1);
    chk("high buffer", 3'h5, last_cmd);
    press(0, 1'h0);
    chk("low buffer", 3'h4, last_cmd);
    chk("buffer runs", 2, n_cmd);
    press(7, 1'h1);
    chk("enable", 1'h1, drive_enable);
    chk("enable quiet", 7, n_task + n_home + n_cmd + n_js);
    bus(1'h0, `DIDF_STATUS_OFS, 32'h0);
    chk("status", 32'h0001_0040, q);
    $display("latch and buffer test done");
  endtask

  initial
  begin
    repeat (20000) @(posedge hclk);
    $display("ERROR watchdog expected finish seen timeout");
    fail_count++;
    close_out();
  end
  initial
  begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    t_reset();
    t_task();
    t_select();
    t_jog();
    t_fault();
    t_misc();
    close_out();
  end
endmodule
